// *** src/nbp_consts.svh ***
/*
 * Offsets, field positions, reset values and counts of the block protect and ECC map.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef NBP_CONSTS_SVH
`define NBP_CONSTS_SVH

// Register byte offsets on the AHB-Lite bus
`define NBP_OFS_CTRL 8'h00
`define NBP_OFS_PROT 8'h04
`define NBP_OFS_STATUS 8'h08
`define NBP_OFS_IRQ_STAT 8'h0C
`define NBP_OFS_IRQ_MASK 8'h10
`define NBP_OFS_RANGE 8'h14
`define NBP_OFS_INFO 8'h18

// Control register fields and reset value
`define NBP_CTRL_ECC_EN 0
`define NBP_CTRL_RESET_VAL 32'h0000_0001
`define NBP_CTRL_ECC_RESET 1'b1

// Protect register fields
`define NBP_PROT_SIZE_LSB 0
`define NBP_PROT_LOW_END 4
`define NBP_PROT_RESET_VAL 5'h00

// Status register fields
`define NBP_ST_BUSY 0
`define NBP_ST_PFAIL 1
`define NBP_ST_EFAIL 2
`define NBP_ST_ECC_LSB 4
`define NBP_ST_BAD_BLOCK 6

// Interrupt status bits
`define NBP_IRQ_REJECT 0
`define NBP_IRQ_DONE 1
`define NBP_IRQ_UNCORR 2
`define NBP_IRQ_BAD 3
`define NBP_IRQ_W 4

// Array geometry
`define NBP_BLOCKS 11'h400
`define NBP_MIN_VALID 11'h3EC
`define NBP_ALL_CODE 4'hA
`define NBP_ECC_AREA_LO 12'h840
`define NBP_BBM_GOOD 8'hFF

// ECC status encodings
`define NBP_ECC_OK 2'h0
`define NBP_ECC_FOUR 2'h1
`define NBP_ECC_FAIL 2'h2
`define NBP_ECC_LIMIT 3'h4

// Link opcodes and frame lengths
`define NBP_OPC_PROG 8'h10
`define NBP_OPC_ERASE 8'hD8
`define NBP_OPC_READ 8'h13
`define NBP_OPC_RESET 8'hFF
`define NBP_FRAME_SHORT 5'h08
`define NBP_FRAME_LONG 5'h18

`endif

// *** src/nbp_pkg.sv ***
/*
 * Types shared by the block protect and ECC map.
 * Assumes the constants header for numeric values.
 */
package nbp_pkg;
	// Command decoded from one link frame
	typedef struct packed {
		logic [7:0] op;
		logic [15:0] page;
	} nbp_cmd_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_GEN = 2'b01,
		ST_WAIT = 2'b10
	} nbp_state_t;

	// Array operation kinds
	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_PROG = 2'b01,
		OP_ERASE = 2'b10
	} nbp_op_t;
endpackage

// *** src/nbp_prot_decode.sv ***
/*
 * Decodes the protect size field and end selector into a block range.
 * Assumes stable register inputs; purely combinational.
 */
`timescale 1ns/1ns
`include "nbp_consts.svh"

module nbp_prot_decode (
	input wire logic [3:0] size,
	input wire logic low_end,
	output logic none,
	output logic [9:0] lo,
	output logic [9:0] hi
);
	// Number of protected blocks, 2^size
	logic [10:0] count;

	// Range decode
	always_comb
	begin
		count = 11'h001 << size[3:0];
		none = (size == 4'h0);
		lo = 10'h000;
		hi = 10'h3FF;
		if (size >= `NBP_ALL_CODE)
		begin
			// Whole array
			lo = 10'h000;
			hi = 10'h3FF;
		end
		else if (low_end)
		begin
			// Lowest blocks
			lo = 10'h000;
			hi = 10'(count - 11'h001);
		end
		else
		begin
			// Highest blocks
			lo = 10'(`NBP_BLOCKS - count);
			hi = 10'h3FF;
		end
	end
endmodule

// *** src/nbp_link_rx.sv ***
/*
 * Serial link receiver: samples clock, select and data pins on hclk and frames commands.
 * Assumes frames of 8 bits (opcode) or 24 bits (opcode, page address), MSB first.
 */
`timescale 1ns/1ns
`include "nbp_consts.svh"

module nbp_link_rx (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output nbp_pkg::nbp_cmd_t cmd,
	output logic cmd_valid
);
	// Synchroniser stages; bit 0 clock, 1 select, 2 data
	logic [2:0] s1_q, s2_q, s3_q;
	// Filtered pin levels
	logic [2:0] f_q, f_d;
	// Shift register and bit count
	logic [23:0] sh_q, sh_d;
	logic [4:0] cnt_q, cnt_d;
	// Output command
	nbp_pkg::nbp_cmd_t cmd_q, cmd_d;
	logic vld_q, vld_d;

	// Next state of the framer
	always_comb
	begin
		// A level counts once the second and third stage agree
		f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
		sh_d = sh_q;
		cnt_d = cnt_q;
		cmd_d = cmd_q;
		vld_d = 1'b0;
		if (f_d[1])
		begin
			// Select high: frame ends here
			cnt_d = 5'h00;
			if (!f_q[1] && cnt_q == `NBP_FRAME_LONG)
			begin
				cmd_d.op = sh_q[23:16];
				cmd_d.page = sh_q[15:0];
				vld_d = 1'b1;
			end
			else if (!f_q[1] && cnt_q == `NBP_FRAME_SHORT)
			begin
				cmd_d.op = sh_q[7:0];
				cmd_d.page = 16'h0000;
				vld_d = 1'b1;
			end
		end
		else if (f_d[0] && !f_q[0] && cnt_q != 5'h1F)
		begin
			// Rising link clock edge shifts one bit
			sh_d = {sh_q[22:0], f_d[2]};
			cnt_d = cnt_q + 5'h01;
		end
	end

	// Registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_q <= 3'h2;
			s2_q <= 3'h2;
			s3_q <= 3'h2;
			f_q <= 3'h2;
			sh_q <= 24'h00_0000;
			cnt_q <= 5'h00;
			cmd_q <= '0;
			vld_q <= 1'b0;
		end
		else
		begin
			s1_q <= {si, cs_n, sclk};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			cmd_q <= cmd_d;
			vld_q <= vld_d;
		end
	end

	assign cmd = cmd_q;
	assign cmd_valid = vld_q;
endmodule

// *** src/nbp_map.sv ***
/*
 * Block protect and on-die ECC control of a serial NAND: AHB-Lite registers, link
 * command checking, array sequencing, ECC status and the power-on page load.
 * Assumes an array back end that answers arr_start with arr_done and ECC results.
 */
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "nbp_consts.svh"

// Functional notes
// - Reserved status bits written zero have no effect
// - Protect field decodes to top or bottom range
// - Program or erase into protected range ignored
// - At least 1004 of 1024 blocks valid
// - Factory bad blocks marked non-FFh at byte 2048
// - Correction enabled after power-up
// - Program computes check codes before array write
// - Read corrects data in cache before output
// - Corrected read updates correction status
// - Writes to check-code bytes discarded with correction
// - Power-on loads block 0 page 0 corrected
// - Four sectors pair with four spare fields
// - Correction status codes 00, 01, 10
// - Protected program or erase sets fail bit
// - Correction status cleared by reset
module nbp_map #(
	parameter logic [10:0] MIN_VALID = `NBP_MIN_VALID
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic arr_start,
	output logic [1:0] arr_op,
	output logic [15:0] arr_page,
	output logic arr_ecc,
	input wire logic arr_done,
	output logic ecc_gen_start,
	input wire logic ecc_gen_done,
	input wire logic [11:0] ecc_err_cnt,
	input wire logic [3:0] ecc_uncorr,
	input wire logic [7:0] bbm_byte,
	input wire logic cache_wr_req,
	input wire logic [11:0] cache_wr_addr,
	output logic cache_wr_en
);
	// Link command
	nbp_pkg::nbp_cmd_t cmd;
	logic cmd_valid;
	// Decoded protected range
	logic prot_none;
	logic [9:0] prot_lo, prot_hi;
	// Bus address phase capture
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [31:0] rdata_q, rdata_d;
	// Software registers
	logic ecc_en_q, ecc_en_d;
	logic [4:0] prot_q, prot_d;
	logic [`NBP_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
	logic irq_q, irq_d;
	// Device status
	logic pfail_q, pfail_d, efail_q, efail_d, bad_q, bad_d;
	logic [1:0] ecc_st_q, ecc_st_d;
	// Sequencer
	nbp_pkg::nbp_state_t st_q, st_d;
	nbp_pkg::nbp_op_t op_q, op_d;
	logic [15:0] page_q, page_d;
	logic por_q, por_d;
	logic start_q, start_d, gen_q, gen_d, ecc_op_q, ecc_op_d;
	// Cache write gate
	logic cwe_q, cwe_d;
	// Events raised this cycle
	logic [`NBP_IRQ_W-1:0] ev;
	logic [`NBP_IRQ_W-1:0] clr;
	logic wr_hit;

	// Summary of per-sector results; each sector covers its spare field too
	function automatic logic [1:0] ecc_code(input logic [11:0] cnt, input logic [3:0] unc);
		logic [1:0] code;
		code = `NBP_ECC_OK;
		for (int i = 0; i < 4; i++)
		begin
			if (cnt[i*3 +: 3] == `NBP_ECC_LIMIT && code == `NBP_ECC_OK)
				code = `NBP_ECC_FOUR;
		end
		if (unc != 4'h0)
			code = `NBP_ECC_FAIL;
		return code;
	endfunction

	// Register read mux
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`NBP_OFS_CTRL: v[`NBP_CTRL_ECC_EN] = ecc_en_q;
			`NBP_OFS_PROT: v[4:0] = prot_q;
			`NBP_OFS_STATUS:
			begin
				v[`NBP_ST_BUSY] = (st_q != nbp_pkg::ST_IDLE) || por_q;
				v[`NBP_ST_PFAIL] = pfail_q;
				v[`NBP_ST_EFAIL] = efail_q;
				v[`NBP_ST_ECC_LSB +: 2] = ecc_st_q;
				v[`NBP_ST_BAD_BLOCK] = bad_q;
			end
			`NBP_OFS_IRQ_STAT: v[`NBP_IRQ_W-1:0] = ist_q;
			`NBP_OFS_IRQ_MASK: v[`NBP_IRQ_W-1:0] = imask_q;
			`NBP_OFS_RANGE: v = {6'h00, prot_hi, 5'h00, prot_none, prot_lo};
			`NBP_OFS_INFO: v = {5'h00, `NBP_BLOCKS, 5'h00, MIN_VALID};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Link receiver
	nbp_link_rx u_rx (
		.hclk(hclk),
		.hresetn(hresetn),
		.sclk(sclk),
		.cs_n(cs_n),
		.si(si),
		.cmd(cmd),
		.cmd_valid(cmd_valid)
	);

	// Protect range decoder
	nbp_prot_decode u_dec (
		.size(prot_q[3:0]),
		.low_end(prot_q[`NBP_PROT_LOW_END]),
		.none(prot_none),
		.lo(prot_lo),
		.hi(prot_hi)
	);

	// Next values of bus, registers and sequencer
	always_comb
	begin
		wr_pend_d = 1'b0;
		wr_addr_d = wr_addr_q;
		rdata_d = rdata_q;
		ecc_en_d = ecc_en_q;
		prot_d = prot_q;
		imask_d = imask_q;
		pfail_d = pfail_q;
		efail_d = efail_q;
		bad_d = bad_q;
		ecc_st_d = ecc_st_q;
		st_d = st_q;
		op_d = op_q;
		page_d = page_q;
		por_d = por_q;
		start_d = 1'b0;
		gen_d = 1'b0;
		ecc_op_d = ecc_op_q;
		ev = '0;
		clr = '0;
		// Address phase: reads answer with zero wait, writes land next cycle
		if (hsel && hready && htrans[1])
		begin
			wr_pend_d = hwrite;
			wr_addr_d = haddr[7:0];
			if (!hwrite)
				rdata_d = rd_mux(haddr[7:0]);
		end
		// Data phase of a write
		wr_hit = wr_pend_q;
		if (wr_hit)
		begin
			case (wr_addr_q)
				`NBP_OFS_CTRL: ecc_en_d = hwdata[`NBP_CTRL_ECC_EN];
				// Only field bits stored; reserved bits have no effect
				`NBP_OFS_PROT: prot_d = hwdata[4:0];
				`NBP_OFS_IRQ_STAT: clr = hwdata[`NBP_IRQ_W-1:0];
				`NBP_OFS_IRQ_MASK: imask_d = hwdata[`NBP_IRQ_W-1:0];
				default: ;
			endcase
		end
		// Sequencer
		case (st_q)
			nbp_pkg::ST_IDLE:
			begin
				if (por_q)
				begin
					// Boot load of block 0 page 0 with correction
					op_d = nbp_pkg::OP_READ;
					page_d = 16'h0000;
					ecc_op_d = ecc_en_q;
					start_d = 1'b1;
					por_d = 1'b0;
					st_d = nbp_pkg::ST_WAIT;
				end
				else if (cmd_valid)
				begin
					case (cmd.op)
						`NBP_OPC_PROG, `NBP_OPC_ERASE:
						begin
							// Range check before any internal cycle
							if (!prot_none && cmd.page[15:6] >= prot_lo && cmd.page[15:6] <= prot_hi)
							begin
								// Refused: array left untouched
								pfail_d = pfail_q | (cmd.op == `NBP_OPC_PROG);
								efail_d = efail_q | (cmd.op == `NBP_OPC_ERASE);
								ev[`NBP_IRQ_REJECT] = 1'b1;
							end
							else if (cmd.op == `NBP_OPC_PROG)
							begin
								pfail_d = 1'b0;
								efail_d = 1'b0;
								op_d = nbp_pkg::OP_PROG;
								page_d = cmd.page;
								ecc_op_d = ecc_en_q;
								if (ecc_en_q)
								begin
									// Encode cache contents first
									gen_d = 1'b1;
									st_d = nbp_pkg::ST_GEN;
								end
								else
								begin
									start_d = 1'b1;
									st_d = nbp_pkg::ST_WAIT;
								end
							end
							else
							begin
								pfail_d = 1'b0;
								efail_d = 1'b0;
								op_d = nbp_pkg::OP_ERASE;
								page_d = cmd.page;
								ecc_op_d = 1'b0;
								start_d = 1'b1;
								st_d = nbp_pkg::ST_WAIT;
							end
						end
						`NBP_OPC_READ:
						begin
							op_d = nbp_pkg::OP_READ;
							page_d = cmd.page;
							ecc_op_d = ecc_en_q;
							start_d = 1'b1;
							st_d = nbp_pkg::ST_WAIT;
						end
						`NBP_OPC_RESET:
						begin
							// Reset command clears correction and fail status, bad-block bit kept; correction enable kept
							ecc_st_d = `NBP_ECC_OK;
							pfail_d = 1'b0;
							efail_d = 1'b0;
						end
						default: ;
					endcase
				end
			end
			nbp_pkg::ST_GEN:
			begin
				// Array write starts only after check codes exist
				if (ecc_gen_done)
				begin
					start_d = 1'b1;
					st_d = nbp_pkg::ST_WAIT;
				end
			end
			nbp_pkg::ST_WAIT:
			begin
				if (arr_done)
				begin
					ev[`NBP_IRQ_DONE] = 1'b1;
					if (op_q == nbp_pkg::OP_READ)
					begin
						if (ecc_op_q)
						begin
							ecc_st_d = ecc_code(ecc_err_cnt, ecc_uncorr);
							ev[`NBP_IRQ_UNCORR] = (ecc_uncorr != 4'h0);
						end
						// First page of a block carries the bad-block mark
						if (page_q[5:0] == 6'h00)
						begin
							bad_d = (bbm_byte != `NBP_BBM_GOOD);
							ev[`NBP_IRQ_BAD] = (bbm_byte != `NBP_BBM_GOOD);
						end
					end
					st_d = nbp_pkg::ST_IDLE;
				end
			end
			default: st_d = nbp_pkg::ST_IDLE;
		endcase
		// Sticky events: set wins over write-one-clear
		ist_d = (ist_q & ~clr) | ev;
		irq_d = |(ist_d & imask_d);
		// Check-code bytes are write-protected while correction is on
		cwe_d = cache_wr_req && !(ecc_en_q && cache_wr_addr >= `NBP_ECC_AREA_LO);
	end

	// Registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			ecc_en_q <= `NBP_CTRL_ECC_RESET;
			prot_q <= `NBP_PROT_RESET_VAL;
			ist_q <= '0;
			imask_q <= '0;
			irq_q <= 1'b0;
			pfail_q <= 1'b0;
			efail_q <= 1'b0;
			bad_q <= 1'b0;
			ecc_st_q <= `NBP_ECC_OK;
			st_q <= nbp_pkg::ST_IDLE;
			op_q <= nbp_pkg::OP_READ;
			page_q <= 16'h0000;
			por_q <= 1'b1;
			start_q <= 1'b0;
			gen_q <= 1'b0;
			ecc_op_q <= 1'b0;
			cwe_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q <= rdata_d;
			ecc_en_q <= ecc_en_d;
			prot_q <= prot_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			irq_q <= irq_d;
			pfail_q <= pfail_d;
			efail_q <= efail_d;
			bad_q <= bad_d;
			ecc_st_q <= ecc_st_d;
			st_q <= st_d;
			op_q <= op_d;
			page_q <= page_d;
			por_q <= por_d;
			start_q <= start_d;
			gen_q <= gen_d;
			ecc_op_q <= ecc_op_d;
			cwe_q <= cwe_d;
		end
	end

	// Outputs straight from flip-flops, hreadyout and hresp tied off; slave never waits or errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign irq = irq_q;
	assign arr_start = start_q;
	assign arr_op = op_q;
	assign arr_page = page_q;
	assign arr_ecc = ecc_op_q;
	assign ecc_gen_start = gen_q;
	assign cache_wr_en = cwe_q;
endmodule

// *** test/nbp_map_checker.sv ***
/*
 * Port checker of the protect map: array strobes, power-on load, cache write gate.
 * Assumes binding onto nbp_map and a single hclk domain.
 */
`timescale 1ns/1ns
module nbp_map_checker #(
	parameter logic [10:0] MIN_VALID = 11'h3EC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic arr_start,
	input wire logic [1:0] arr_op,
	input wire logic [15:0] arr_page,
	input wire logic arr_ecc,
	input wire logic ecc_gen_start,
	input wire logic ecc_gen_done,
	input wire logic cache_wr_req,
	input wire logic [11:0] cache_wr_addr,
	input wire logic cache_wr_en
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Slave never stalls and always answers OKAY
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	a_power_load: assert property ($rose(hresetn) |-> ##[0:1] (arr_start && arr_op == 2'd0 && arr_ecc))
		else $error("no corrected page load after reset");
	a_load_page: assert property ($rose(hresetn) |-> ##[0:1] (arr_page == 16'h0000))
		else $error("power-on load not at block zero");
	a_gen_then_prog: assert property (ecc_gen_done |=> arr_start && arr_op == 2'd1 && arr_ecc)
		else $error("program did not follow check code generation");
	a_prog_after_gen: assert property (arr_start && arr_op == 2'd1 && arr_ecc |-> $past(ecc_gen_done))
		else $error("corrected program started without check codes");
	a_main_area: assert property (cache_wr_req && cache_wr_addr < 12'h840 |=> cache_wr_en)
		else $error("data area write dropped");
	a_wr_cause: assert property (cache_wr_en |-> $past(cache_wr_req))
		else $error("cache write without request");
	a_op_stands: assert property (!arr_start && !ecc_gen_start |-> $stable(arr_op) && $stable(arr_page) && $stable(arr_ecc))
		else $error("operation fields moved without a start");
	a_start_gap: assert property (arr_start |=> !arr_start [*3])
		else $error("second start while busy");
endmodule

bind nbp_map nbp_map_checker #(.MIN_VALID(MIN_VALID)) nbp_map_checker_inst (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .arr_start(arr_start), .arr_op(arr_op), .arr_page(arr_page),
	.arr_ecc(arr_ecc), .ecc_gen_start(ecc_gen_start), .ecc_gen_done(ecc_gen_done), .cache_wr_req(cache_wr_req),
	.cache_wr_addr(cache_wr_addr), .cache_wr_en(cache_wr_en));

// *** test/nbp_host_link.sv ***
/*
 * Host flash controller model: frames opcode and page bits onto the serial pins.
 * Assumes the block samples the pins on its own clock.
 */
`timescale 1ns/1ns
module nbp_host_link (
	output logic sclk,
	output logic cs_n,
	output logic si
);
	// Idle: deselected, clock standing still
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Deselected data keeps toggling so a stale bit never looks valid
	always #200
		if (cs_n)
			si = ~si;
	// Sends n bits of v, most significant first, 400 ns a bit
	task automatic send(input logic [23:0] v, input int n);
		#7 cs_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			si = v[23 - i];
			#200 sclk = 1'b1;
			#200 sclk = 1'b0;
		end
		#200 cs_n = 1'b1;
	endtask
endmodule

// *** test/tb.sv ***
/*
 * Self-checking bench of the protect map: bus tasks, array back end, reference model.
 * Assumes the host link model and the bound checker.
 */
`timescale 1ns/1ns
`include "nbp_consts.svh"
module tb;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, arr_op, last_op;
	logic [2:0] hsize;
	logic sclk, cs_n, si, arr_start, arr_ecc, arr_done, ecc_gen_start, ecc_gen_done, last_ecc;
	logic [15:0] arr_page, last_page, pg;
	logic [11:0] ecc_err_cnt, cache_wr_addr;
	logic [3:0] ecc_uncorr;
	logic [7:0] bbm_byte;
	logic cache_wr_req, cache_wr_en;
	int fail_count, checked, cyc, starts, gens, gc, ac;
	assign hready = hreadyout;
	nbp_map nbp_map_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq(irq), .sclk(sclk), .cs_n(cs_n), .si(si),
		.arr_start(arr_start), .arr_op(arr_op), .arr_page(arr_page), .arr_ecc(arr_ecc),
		.arr_done(arr_done), .ecc_gen_start(ecc_gen_start), .ecc_gen_done(ecc_gen_done),
		.ecc_err_cnt(ecc_err_cnt), .ecc_uncorr(ecc_uncorr), .bbm_byte(bbm_byte),
		.cache_wr_req(cache_wr_req), .cache_wr_addr(cache_wr_addr), .cache_wr_en(cache_wr_en));
	nbp_host_link nbp_host_link_inst (.sclk(sclk), .cs_n(cs_n), .si(si));
	// 20 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// Array back end: answers encoder and array requests, counts starts; cuts a hang short
	always @(posedge hclk)
	begin
		ecc_gen_done <= (gc == 1);
		arr_done <= (ac == 1);
		gc <= ecc_gen_start ? 3 : (gc > 0 ? gc - 1 : 0);
		ac <= arr_start ? 4 : (ac > 0 ? ac - 1 : 0);
		gens += ecc_gen_start;
		if (arr_start)
		begin
			starts++;
			last_op = arr_op;
			last_ecc = arr_ecc;
			last_page = arr_page;
		end
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One single-word transfer; read data lands in rd
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0000_00, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Link frame, then time for the block to act
	task automatic cmd(input logic [7:0] op, input logic [15:0] pg, input int n);
		nbp_host_link_inst.send({op, pg}, n);
		repeat (30) @(posedge hclk);
	endtask
	// Host cache write attempt; gate seen one cycle later
	task automatic cw(input logic [11:0] a, input logic e);
		cache_wr_req <= 1'b1;
		cache_wr_addr <= a;
		@(posedge hclk);
		cache_wr_req <= 1'b0;
		#1 chk("cache_wr_en", cache_wr_en, e);
		@(posedge hclk);
	endtask
	// Reference protected-range decode
	function automatic bit prot(input int blk, input int sz, input bit low);
		if (sz == 0)
			return 0;
		if (sz >= 10)
			return 1;
		return low ? blk < (1 << sz) : blk >= 1024 - (1 << sz);
	endfunction
	task automatic test_done();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		int sz, blk, e, pf, ef, s0, g0;
		bit low, rf, pr;
		logic [11:0] c;
		logic [3:0] uc;
		logic [7:0] bb;
		{hresetn, hwrite, cache_wr_req, gc, ac} = '0;
		{haddr, htrans, hwdata, ecc_err_cnt, ecc_uncorr, bbm_byte, cache_wr_addr} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		void'($urandom(32'hcbcc7215));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (10) @(posedge hclk);
		chk("load", {starts[1:0], last_op, last_ecc}, 5'h09);
		ahb(0, `NBP_OFS_CTRL, 0);
		chk("ctrl", rd, 32'h0000_0001);
		ahb(0, `NBP_OFS_INFO, 0);
		chk("info", rd, 32'h0400_03EC);
		ahb(0, 8'h1C, 0);
		chk("unmapped", rd, 32'h0000_0000);
		for (int i = 0; i < 32; i++)
		begin
			sz = i % 16;
			ahb(1, `NBP_OFS_PROT, i[4:0]);
			ahb(0, `NBP_OFS_RANGE, 0);
			if (sz == 0)
				chk("none", rd[10], 1);
			else
				chk("range", rd & 32'h03FF_07FF, ((sz >= 10 || i < 16) ? 1023 << 16 : ((1 << sz) - 1) << 16)
					| ((sz >= 10 || i >= 16) ? 0 : 1024 - (1 << sz)));
		end
		ahb(1, `NBP_OFS_IRQ_MASK, 32'h0000_0001);
		{pf, ef} = '0;
		for (int i = 0; i < 12; i++)
		begin
			sz = $urandom_range(1, 9);
			low = $urandom_range(0, 1);
			blk = $urandom_range(0, 1023);
			pr = i[0];
			rf = prot(blk, sz, low);
			ahb(1, `NBP_OFS_PROT, {low, sz[3:0]});
			s0 = starts;
			g0 = gens;
			pg = {blk[9:0], 6'($urandom)};
			cmd(pr ? `NBP_OPC_PROG : `NBP_OPC_ERASE, pg, 24);
			chk("start", starts - s0, !rf);
			if (!rf)
				chk("op_page", {last_op, last_page}, {pr ? 2'd1 : 2'd2, pg});
			chk("gen", gens - g0, pr && !rf);
			pf = rf ? pf | pr : 0;
			ef = rf ? ef | !pr : 0;
			ahb(0, `NBP_OFS_STATUS, 0);
			chk("fail", rd[2:1], {ef[0], pf[0]});
			chk("irq", irq, rf);
			ahb(1, `NBP_OFS_IRQ_STAT, 32'h0000_000F);
		end
		for (int k = 0; k < 6; k++)
		begin
			c = 12'($urandom) & 12'h6DB;
			if (k % 3 == 1)
				c[3 * (k % 4) +: 3] = 3'd4;
			uc = (k % 3 == 2) ? 4'($urandom_range(1, 15)) : 4'h0;
			bb = k[0] ? 8'hFF : 8'($urandom);
			e = uc != 0 ? 2 : int'(k % 3 == 1);
			ecc_err_cnt <= c;
			ecc_uncorr <= uc;
			bbm_byte <= bb;
			cmd(`NBP_OPC_READ, {10'($urandom), 6'h00}, 24);
			chk("rd_ecc", last_ecc, 1);
			chk("irq_masked", irq, 0);
			ahb(0, `NBP_OFS_STATUS, 0);
			chk("ecc_st", rd[6:4], {bb != 8'hFF, e[1:0]});
			ahb(0, `NBP_OFS_IRQ_STAT, 0);
			chk("istat", rd[3:0], {bb != 8'hFF, uc != 0, 2'b10});
			ahb(1, `NBP_OFS_IRQ_STAT, 32'h0000_000F);
		end
		ahb(1, `NBP_OFS_STATUS, 0);
		ahb(0, `NBP_OFS_STATUS, 0);
		chk("rsvd", rd[5:4], 2'b10);
		cmd(`NBP_OPC_RESET, 0, 8);
		ahb(0, `NBP_OFS_STATUS, 0);
		chk("rst_st", {rd[5:4], rd[2:1]}, 0);
		ahb(1, `NBP_OFS_CTRL, 0);
		ahb(1, `NBP_OFS_PROT, 0);
		g0 = gens;
		cmd(`NBP_OPC_PROG, 16'h0040, 24);
		chk("raw_prog", gens - g0, 0);
		chk("raw_ecc", last_ecc, 0);
		cw(12'h840, 1);
		ahb(1, `NBP_OFS_CTRL, 1);
		cw(12'h840, 0);
		cw(12'h83F, 1);
		test_done();
	end
endmodule
